// [rtl/hs_clk_pkg.sv]
// Constants and types for the status and clock-output register bank
// Operation
// - Eight latched lane-align flags at bits 15:8
// - Bits 1:0 latch main FIFO underflow, overflow
// - Bits 3:2 latch alternate FIFO underflow, overflow
// - Enable bit 9, reset 1, else park output p low, n high
// - Power-down bit 8, reset 0, disables driver
// - Divide field 7:4 divides selected clock
// - Codes 0000,1000,1001,1010 divide 1,4,8,16
// - Codes 1100,1101,1110 divide 5,10,20
// - Code 1111 divides by 25
// - Code 0110 divides by two
// - Select 00x0,00x1,010x route macro A clocks
// - Select 0110,0111 route lanes 0-3 clocks
// - Select 10x0,10x1,110x route macro B clocks
// - Select 1110 routes lanes 4-7 recovered clock
// - Select field resets to 0000
// - Control bits 15:10 read as zero
package hs_clk_pkg;

   // ----------------------------------------------------------------
   // Management frame
   // ----------------------------------------------------------------
   localparam logic [5:0]  PREAMBLE_ONES   = 6'h20;
   localparam logic [4:0]  HEADER_BITS     = 5'h0E;
   localparam logic [4:0]  DATA_BITS       = 5'h10;
   localparam logic [1:0]  START_CODE      = 2'h1;
   localparam logic [1:0]  OP_WRITE        = 2'h1;
   localparam logic [1:0]  OP_READ         = 2'h2;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [4:0]  STATUS_ADDR     = 5'h14;
   localparam logic [4:0]  CTRL_ADDR       = 5'h15;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;
   localparam logic [15:0] CTRL_RESET      = 16'h0280;
   localparam logic [15:0] CTRL_WRITE_MASK = 16'h03FF;
   localparam int          ALIGN_LSB       = 8;
   localparam int          FIFO_LSB        = 0;
   localparam int          EN_BIT          = 9;
   localparam int          PD_BIT          = 8;
   localparam int          DIV_LSB         = 4;
   localparam int          SEL_LSB         = 0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_PREAMBLE = 2'h0,
      ST_HEADER   = 2'h1,
      ST_TURN     = 2'h3,
      ST_DATA     = 2'h2
   } mdio_state_t;

   localparam logic [3:0]  NO_SOURCE       = 4'h9;

   // ----------------------------------------------------------------
   // Divide code to ratio
   // ----------------------------------------------------------------
   function automatic logic [4:0] divide_ratio(input logic [3:0] code);
      unique case (code)
         4'h0:    divide_ratio = 5'h01;
         4'h8:    divide_ratio = 5'h04;
         4'h9:    divide_ratio = 5'h08;
         4'hA:    divide_ratio = 5'h10;
         4'h6:    divide_ratio = 5'h02;
         4'h4:    divide_ratio = 5'h02;
         4'hC:    divide_ratio = 5'h05;
         4'hD:    divide_ratio = 5'h0A;
         4'hE:    divide_ratio = 5'h14;
         4'hF:    divide_ratio = 5'h19;
         default: divide_ratio = 5'h01;
      endcase
   endfunction : divide_ratio

endpackage : hs_clk_pkg

// [rtl/latched_flag_bank.sv]
// Latched-high status flags with clear on read
`timescale 1ns/1ns
module latched_flag_bank
   import hs_clk_pkg::*;
#(
   parameter int WIDTH = 12
) (
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] condition,
   input  wire logic             read_clear,
   output logic      [WIDTH-1:0] flags
);

   if (WIDTH < 1) begin : g_check
      $error("latched_flag_bank needs WIDTH of one or more");
   end

   logic [WIDTH-1:0] next_flags;

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   always_comb begin
      next_flags = condition | (flags & ~{WIDTH{read_clear}});
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end

endmodule : latched_flag_bank

// [rtl/clock_out_divider.sv]
// Divider and output stage for the differential clock output
`timescale 1ns/1ns
module clock_out_divider
   import hs_clk_pkg::*;
#(
   parameter int COUNT_WIDTH = 5
) (
   input  wire logic                   ref_clk,
   input  wire logic                   sys_rst,
   input  wire logic                   source_clk,
   input  wire logic [COUNT_WIDTH-1:0] ratio,
   input  wire logic                   toggle_enable,
   input  wire logic                   power_down,
   output logic                        clock_out_p,
   output logic                        clock_out_n,
   output logic                        driver_off
);

   if (COUNT_WIDTH < 5) begin : g_check
      $error("clock_out_divider needs COUNT_WIDTH of five or more");
   end

   logic                   src_q;
   logic                   src_prev;
   logic [COUNT_WIDTH-1:0] cnt;
   logic [COUNT_WIDTH-1:0] next_cnt;
   logic                   next_p;
   logic                   next_n;
   logic                   level;

   // ----------------------------------------------------------------
   // Divide
   // ----------------------------------------------------------------
   // Odd ratios above one give an uneven duty; the source is only sampled
   always_comb begin
      next_cnt = cnt;
      if (src_q && !src_prev) begin
         if (cnt >= COUNT_WIDTH'(ratio - 1'b1)) begin
            next_cnt = '0;
         end else begin
            next_cnt = COUNT_WIDTH'(cnt + 1'b1);
         end
      end
      if (ratio <= COUNT_WIDTH'(1)) begin
         level = src_q;
      end else begin
         level = (next_cnt < COUNT_WIDTH'((ratio + 1'b1) >> 1));
      end
      if (power_down) begin
         next_p = 1'b0;
         next_n = 1'b0;
      end else if (!toggle_enable) begin
         next_p = 1'b0;
         next_n = 1'b1;
      end else begin
         next_p = level;
         next_n = ~level;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         src_q       <= 1'b0;
         src_prev    <= 1'b0;
         cnt         <= '0;
         clock_out_p <= 1'b0;
         clock_out_n <= 1'b1;
         driver_off  <= 1'b0;
      end else begin
         src_q       <= source_clk;
         src_prev    <= src_q;
         cnt         <= next_cnt;
         clock_out_p <= next_p;
         clock_out_n <= next_n;
         driver_off  <= power_down;
      end
   end

endmodule : clock_out_divider

// [rtl/hs_status_and_clkout_control.sv]
// Status and clock-output registers behind a management serial port
`timescale 1ns/1ns
module hs_status_and_clkout_control
   import hs_clk_pkg::*;
#(
   parameter logic [4:0] PHY_ADDRESS = 5'h00
) (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   // Management port
   input  wire logic mdc,
   input  wire logic mdio_in,
   output logic      mdio_out,
   output logic      mdio_oe,
   // Alignment conditions
   input  wire logic rx_group3_aligned,
   input  wire logic rx_group2_aligned,
   input  wire logic tx_group3_aligned,
   input  wire logic tx_group2_aligned,
   input  wire logic rx_group1_aligned,
   input  wire logic rx_group0_aligned,
   input  wire logic tx_group1_aligned,
   input  wire logic tx_group0_aligned,
   // Lane FIFO events
   input  wire logic alt_rx_fifo_underflow,
   input  wire logic alt_rx_fifo_overflow,
   input  wire logic main_rx_fifo_underflow,
   input  wire logic main_rx_fifo_overflow,
   // Clock sources
   input  wire logic macro_a_rx_byte_clk,
   input  wire logic macro_a_tx_byte_clk,
   input  wire logic macro_a_vco_div4_clk,
   input  wire logic lanes_low_rx_byte_clk,
   input  wire logic lanes_low_tx_byte_clk,
   input  wire logic macro_b_rx_byte_clk,
   input  wire logic macro_b_tx_byte_clk,
   input  wire logic macro_b_vco_div4_clk,
   input  wire logic lanes_high_rx_byte_clk,
   // Clock output
   output logic      clock_out_pins_p,
   output logic      clock_out_pins_n,
   output logic      clock_out_power_down
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   mdio_state_t state;
   mdio_state_t next_state;
   logic        mdc_q;
   logic        mdc_prev;
   logic        mdio_q;
   logic        mdc_rise;
   logic        mdc_fall;
   logic [5:0]  ones;
   logic [5:0]  next_ones;
   logic [4:0]  bit_cnt;
   logic [4:0]  next_bit_cnt;
   logic [15:0] shift_in;
   logic [15:0] next_shift_in;
   logic [16:0] out_shift;
   logic [16:0] next_out_shift;
   logic        is_read;
   logic        next_is_read;
   logic [4:0]  reg_addr;
   logic [4:0]  next_reg_addr;
   logic        next_mdio_out;
   logic        next_mdio_oe;
   logic [15:0] ctrl;
   logic [15:0] next_ctrl;
   logic        read_clear;
   logic [13:0] header;
   logic [11:0] flags;
   logic [11:0] condition;
   logic [15:0] status_word;
   logic [9:0]  sources;
   logic        selected_clk;
   logic [3:0]  source_idx;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [3:0] source_index(input logic [3:0] sel);
      casez (sel)
         4'b00?0: source_index = 4'h0;
         4'b00?1: source_index = 4'h1;
         4'b010?: source_index = 4'h2;
         4'b0110: source_index = 4'h3;
         4'b0111: source_index = 4'h4;
         4'b10?0: source_index = 4'h5;
         4'b10?1: source_index = 4'h6;
         4'b110?: source_index = 4'h7;
         4'b1110: source_index = 4'h8;
         default: source_index = NO_SOURCE;
      endcase
   endfunction : source_index

   function automatic logic [15:0] read_word(input logic [4:0] addr,
                                             input logic [15:0] stat,
                                             input logic [15:0] cfg);
      if (addr == STATUS_ADDR) begin
         read_word = stat;
      end else if (addr == CTRL_ADDR) begin
         read_word = cfg;
      end else begin
         read_word = 16'h0000;
      end
   endfunction : read_word

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   // lane-align order
   assign condition[11:4] = {rx_group3_aligned, rx_group2_aligned,
                             tx_group3_aligned, tx_group2_aligned,
                             rx_group1_aligned, rx_group0_aligned,
                             tx_group1_aligned, tx_group0_aligned};
   assign condition[3:2] = {alt_rx_fifo_underflow, alt_rx_fifo_overflow};
   assign condition[1:0] = {main_rx_fifo_underflow, main_rx_fifo_overflow};

   latched_flag_bank #(
      .WIDTH      (12)
   ) u_flags (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .condition  (condition),
      .read_clear (read_clear),
      .flags      (flags)
   );

   always_comb begin
      status_word                      = STATUS_RESET;
      status_word[ALIGN_LSB +: 8]      = flags[11:4];
      status_word[FIFO_LSB +: 4]       = flags[3:0];
   end

   // ----------------------------------------------------------------
   // Management frame engine
   // ----------------------------------------------------------------
   // Pins are synchronous, so edges come from one register stage
   assign mdc_rise = mdc_q & ~mdc_prev;
   assign mdc_fall = ~mdc_q & mdc_prev;
   assign header   = {shift_in[12:0], mdio_q};

   always_comb begin
      next_state     = state;
      next_ones      = ones;
      next_bit_cnt   = bit_cnt;
      next_shift_in  = shift_in;
      next_out_shift = out_shift;
      next_is_read   = is_read;
      next_reg_addr  = reg_addr;
      next_mdio_out  = mdio_out;
      next_mdio_oe   = mdio_oe;
      next_ctrl      = ctrl;
      read_clear     = 1'b0;
      if (mdc_rise) begin
         unique case (state)
            ST_PREAMBLE: begin
               if (mdio_q) begin
                  if (ones < PREAMBLE_ONES) begin
                     next_ones = 6'(ones + 1'b1);
                  end
               end else if (ones == PREAMBLE_ONES) begin
                  next_state    = ST_HEADER;
                  next_bit_cnt  = 5'h01;
                  next_shift_in = 16'h0000;
               end else begin
                  next_ones = 6'h00;
               end
            end
            ST_HEADER: begin
               next_shift_in = {shift_in[14:0], mdio_q};
               next_bit_cnt  = 5'(bit_cnt + 1'b1);
               if (bit_cnt == 5'(HEADER_BITS - 1'b1)) begin
                  next_bit_cnt = 5'h00;
                  next_ones    = 6'h00;
                  next_state   = ST_PREAMBLE;
                  if (header[13:12] == START_CODE && header[9:5] == PHY_ADDRESS &&
                      (header[11:10] == OP_READ || header[11:10] == OP_WRITE)) begin
                     next_state     = ST_TURN;
                     next_is_read   = (header[11:10] == OP_READ);
                     next_reg_addr  = header[4:0];
                     next_out_shift = {1'b0, read_word(header[4:0], status_word, ctrl)};
                     read_clear     = (header[11:10] == OP_READ) &&
                                      (header[4:0] == STATUS_ADDR);
                  end
               end
            end
            ST_TURN: begin
               next_bit_cnt = 5'(bit_cnt + 1'b1);
               if (bit_cnt == 5'h01) begin
                  next_state   = ST_DATA;
                  next_bit_cnt = 5'h00;
               end
            end
            ST_DATA: begin
               next_bit_cnt  = 5'(bit_cnt + 1'b1);
               next_shift_in = {shift_in[14:0], mdio_q};
               if (bit_cnt == 5'(DATA_BITS - 1'b1)) begin
                  next_state   = ST_PREAMBLE;
                  next_bit_cnt = 5'h00;
                  next_ones    = 6'h00;
                  if (!is_read && reg_addr == CTRL_ADDR) begin
                     next_ctrl = {shift_in[14:0], mdio_q} & CTRL_WRITE_MASK;
                  end
               end
            end
         endcase
      end
      if (mdc_fall) begin
         // Drive only from second turnaround bit to last data bit
         if (is_read && ((state == ST_TURN && bit_cnt == 5'h01) || state == ST_DATA)) begin
            next_mdio_oe   = 1'b1;
            next_mdio_out  = out_shift[16];
            next_out_shift = {out_shift[15:0], 1'b0};
         end else begin
            next_mdio_oe  = 1'b0;
            next_mdio_out = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state     <= ST_PREAMBLE;
         mdc_q     <= 1'b0;
         mdc_prev  <= 1'b0;
         mdio_q    <= 1'b1;
         ones      <= 6'h00;
         bit_cnt   <= 5'h00;
         shift_in  <= 16'h0000;
         out_shift <= 17'h00000;
         is_read   <= 1'b0;
         reg_addr  <= 5'h00;
         mdio_out  <= 1'b0;
         mdio_oe   <= 1'b0;
         ctrl      <= CTRL_RESET;
      end else begin
         state     <= next_state;
         mdc_q     <= mdc;
         mdc_prev  <= mdc_q;
         mdio_q    <= mdio_in;
         ones      <= next_ones;
         bit_cnt   <= next_bit_cnt;
         shift_in  <= next_shift_in;
         out_shift <= next_out_shift;
         is_read   <= next_is_read;
         reg_addr  <= next_reg_addr;
         mdio_out  <= next_mdio_out;
         mdio_oe   <= next_mdio_oe;
         ctrl      <= next_ctrl;
      end
   end

   // ----------------------------------------------------------------
   // Clock output path
   // ----------------------------------------------------------------
   assign sources = {1'b0,
                     lanes_high_rx_byte_clk,
                     macro_b_vco_div4_clk, macro_b_tx_byte_clk, macro_b_rx_byte_clk,
                     lanes_low_tx_byte_clk, lanes_low_rx_byte_clk,
                     macro_a_vco_div4_clk, macro_a_tx_byte_clk, macro_a_rx_byte_clk};

   assign source_idx   = source_index(ctrl[SEL_LSB +: 4]);
   assign selected_clk = sources[source_idx];

   clock_out_divider #(
      .COUNT_WIDTH   (5)
   ) u_divider (
      .ref_clk       (ref_clk),
      .sys_rst       (sys_rst),
      .source_clk    (selected_clk),
      .ratio         (divide_ratio(ctrl[DIV_LSB +: 4])),
      .toggle_enable (ctrl[EN_BIT]),
      .power_down    (ctrl[PD_BIT]),
      .clock_out_p   (clock_out_pins_p),
      .clock_out_n   (clock_out_pins_n),
      .driver_off    (clock_out_power_down)
   );

endmodule : hs_status_and_clkout_control

// [test/clkout_ctrl_chk.sv]
// Assertions on the management port and clock output pins
`timescale 1ns/1ns
module clkout_ctrl_chk (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic mdc,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   input wire logic clock_out_pins_p,
   input wire logic clock_out_pins_n,
   input wire logic clock_out_power_down
);
   logic       mdc_q;
   logic [4:0] falls;
   logic [4:0] next_falls;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   // ----------------
   // Falls of mdc while the device drives
   // ----------------
   always_comb begin
      next_falls = falls;
      if (!mdio_oe) begin
         next_falls = 5'h00;
      end else if (mdc_q && !mdc) begin
         next_falls = falls + 5'h01;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mdc_q <= 1'b0;
         falls <= 5'h00;
      end else begin
         mdc_q <= mdc;
         falls <= next_falls;
      end
   end

   // ----------------
   // Properties
   // ----------------
   AST_RESET_STATE: assert property (
      $fell(sys_rst) |-> !clock_out_pins_p && clock_out_pins_n
                         && !clock_out_power_down && !mdio_oe)
      else $error("outputs not at reset levels");
   // Pins may lag the power-down copy by up to two cycles or lead it by one
   AST_PD_PINS_LOW: assert property (
      clock_out_power_down[*4] |-> !$past(clock_out_pins_p) && !$past(clock_out_pins_n))
      else $error("pins active while powered down");
   AST_PINS_OPPOSITE: assert property (
      (!clock_out_power_down)[*4] |-> $past(clock_out_pins_p) != $past(clock_out_pins_n))
      else $error("pins not complementary");
   AST_PD_QUIET: assert property (
      $changed(clock_out_power_down) |-> !mdio_oe && !$past(mdio_oe))
      else $error("power down moved during a read");
   AST_TA_ZERO: assert property (
      $rose(mdio_oe) |-> !mdio_out && !mdc)
      else $error("turnaround bit not zero");
   AST_OUT_NEEDS_OE: assert property (
      mdio_out |-> mdio_oe)
      else $error("data high while released");
   AST_WORD_LENGTH: assert property (
      $fell(mdio_oe) |-> falls == 5'h11)
      else $error("read word length wrong");
   AST_BIT_STANDS: assert property (
      mdio_oe && $past(mdio_oe) && $changed(mdio_out) |-> !mdc)
      else $error("read bit changed while mdc high");

   cover property (clock_out_power_down[*4]);
   cover property ($rose(mdio_oe));
   cover property ($fell(mdio_oe));
endmodule : clkout_ctrl_chk

bind hs_status_and_clkout_control clkout_ctrl_chk u_chk (
   .ref_clk, .sys_rst, .mdc, .mdio_out, .mdio_oe,
   .clock_out_pins_p, .clock_out_pins_n, .clock_out_power_down
);

// [test/mdio_host_model.sv]
// Management host model driving frames onto the shared data wire
`timescale 1ns/1ns
module mdio_host_model
   import hs_clk_pkg::*;
#(
   parameter logic [4:0] PHY = 5'h00
) (
   input  wire logic ref_clk,
   input  wire logic mdio_out,
   input  wire logic mdio_oe,
   output logic      mdc,
   output logic      mdio_wire
);
   logic drive_en;
   logic drive_bit;

   // Pull-up wins when neither side drives
   assign mdio_wire = mdio_oe ? mdio_out : (drive_en ? drive_bit : 1'b1);

   initial begin
      mdc = 1'b0;
      drive_en = 1'b0;
      drive_bit = 1'b1;
   end

   // Five cycles a phase leaves margin over the two-cycle minimum
   task automatic bit_slot(input logic en, input logic b, output logic seen);
      drive_en = en;
      drive_bit = b;
      repeat (5) @(negedge ref_clk);
      seen = mdio_wire;
      mdc = 1'b1;
      repeat (5) @(negedge ref_clk);
      mdc = 1'b0;
   endtask : bit_slot

   task automatic frame(input logic [1:0] op, input logic [4:0] addr,
                        input logic [15:0] wdata, output logic [15:0] rdata);
      logic [13:0] head;
      logic        seen;
      head = {START_CODE, op, PHY, addr};
      repeat (PREAMBLE_ONES) bit_slot(1'b1, 1'b1, seen);
      for (int i = 13; i >= 0; i--) bit_slot(1'b1, head[i], seen);
      bit_slot(op == OP_WRITE, 1'b1, seen);
      bit_slot(op == OP_WRITE, 1'b0, seen);
      for (int i = 15; i >= 0; i--) begin
         bit_slot(op == OP_WRITE, wdata[i], seen);
         rdata[i] = seen;
      end
      drive_en = 1'b0;
      repeat (10) @(negedge ref_clk);
   endtask : frame
endmodule : mdio_host_model

// [test/tb_top.sv]
// Self-checking bench for the status and clock output register bank
`timescale 1ns/1ns
module tb_top
   import hs_clk_pkg::*;
;
   logic        ref_clk;
   logic        sys_rst;
   logic [11:0] cond;
   logic [8:0]  src;
   logic        mdc;
   logic        mdio_wire;
   logic        mdio_out;
   logic        mdio_oe;
   logic        clock_out_pins_p;
   logic        clock_out_pins_n;
   logic        clock_out_power_down;
   logic [15:0] r;
   int          comparisons;
   int          fails;
   int          cycles;
   int          cyc;

   // reserved divide codes left out
   // Both spellings of the divide-by-two code are exercised
   localparam logic [3:0] DIV_CODE [10] = '{4'h0, 4'h8, 4'h9, 4'hA, 4'hC,
                                            4'hD, 4'hE, 4'hF, 4'h6, 4'h4};
   localparam int         DIV_RATIO [10] = '{1, 4, 8, 16, 5, 10, 20, 25, 2, 2};
   localparam int         SRC_OF [15] = '{0, 1, 0, 1, 2, 2, 3, 4, 5, 6, 5, 6, 7, 7, 8};

   hs_status_and_clkout_control DUT (
      .ref_clk, .sys_rst, .mdc, .mdio_in(mdio_wire), .mdio_out, .mdio_oe,
      .rx_group3_aligned(cond[11]), .rx_group2_aligned(cond[10]),
      .tx_group3_aligned(cond[9]), .tx_group2_aligned(cond[8]),
      .rx_group1_aligned(cond[7]), .rx_group0_aligned(cond[6]),
      .tx_group1_aligned(cond[5]), .tx_group0_aligned(cond[4]),
      .alt_rx_fifo_underflow(cond[3]), .alt_rx_fifo_overflow(cond[2]),
      .main_rx_fifo_underflow(cond[1]), .main_rx_fifo_overflow(cond[0]),
      .macro_a_rx_byte_clk(src[0]), .macro_a_tx_byte_clk(src[1]),
      .macro_a_vco_div4_clk(src[2]), .lanes_low_rx_byte_clk(src[3]),
      .lanes_low_tx_byte_clk(src[4]), .macro_b_rx_byte_clk(src[5]),
      .macro_b_tx_byte_clk(src[6]), .macro_b_vco_div4_clk(src[7]),
      .lanes_high_rx_byte_clk(src[8]), .clock_out_pins_p, .clock_out_pins_n,
      .clock_out_power_down
   );

   mdio_host_model host (.ref_clk, .mdio_out, .mdio_oe, .mdc, .mdio_wire);

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Source i toggles every i+2 cycles, so each period names its source
   initial begin
      int cnt [9];
      src = 9'h000;
      cnt = '{default: 0};
      forever begin
         @(negedge ref_clk);
         for (int i = 0; i < 9; i++) begin
            cnt[i]++;
            if (cnt[i] == i + 2) begin
               cnt[i] = 0;
               src[i] = ~src[i];
            end
         end
      end
   end

   initial begin
      cycles = 0;
      forever begin
         @(posedge ref_clk);
         cycles++;
         if (cycles == 80000) begin
            fails++;
            give_verdict();
         end
      end
   end

   // ----------------
   // Tasks
   // ----------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] unused;
      host.frame(OP_WRITE, a, d, unused);
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      host.frame(OP_READ, a, 16'h0000, d);
   endtask : rd

   // Cycles between second and third rise, first period may be partial
   task automatic period(output int c);
      int   rises;
      int   n;
      logic last;
      rises = 0;
      n = 0;
      c = 0;
      last = clock_out_pins_p;
      while (rises < 3 && n < 600) begin
         @(negedge ref_clk);
         n++;
         if (rises == 2) c++;
         if (clock_out_pins_p === 1'b1 && last === 1'b0) rises++;
         last = clock_out_pins_p;
      end
   endtask : period

   task automatic pins_steady(input logic [2:0] exp);
      int bad;
      bad = 0;
      repeat (60) begin
         @(negedge ref_clk);
         if ({clock_out_pins_p, clock_out_pins_n, clock_out_power_down} !== exp) bad++;
      end
      check(16'(bad), 16'h0000);
   endtask : pins_steady

   // ----------------
   // Sequence
   // ----------------
   initial begin
      sys_rst = 1'b1;
      cond = 12'h000;
      comparisons = 0;
      fails = 0;
      repeat (3) @(negedge ref_clk);
      sys_rst = 1'b0;
      @(negedge ref_clk);
      rd(CTRL_ADDR, r);
      check(r, 16'h0280);
      rd(STATUS_ADDR, r);
      check(r, 16'h0000);
      period(cyc);
      check(16'(cyc), 16'h0010);
      for (int i = 0; i < 12; i++) begin
         cond = 12'h001 << i;
         @(negedge ref_clk);
         cond = 12'h000;
         rd(STATUS_ADDR, r);
         check(r, (i < 4) ? 16'h0001 << i : 16'h0010 << i);
      end
      // Condition still present at the read keeps the flag
      cond = 12'h800;
      rd(STATUS_ADDR, r);
      check(r, 16'h8000);
      rd(STATUS_ADDR, r);
      check(r, 16'h8000);
      cond = 12'h000;
      rd(STATUS_ADDR, r);
      check(r, 16'h8000);
      rd(STATUS_ADDR, r);
      check(r, 16'h0000);
      wr(CTRL_ADDR, 16'hFC80);
      rd(CTRL_ADDR, r);
      check(r, 16'h0080);
      pins_steady(3'b010);
      wr(CTRL_ADDR, 16'h0100);
      pins_steady(3'b001);
      wr(5'h16, 16'hFFFF);
      rd(5'h16, r);
      check(r, 16'h0000);
      rd(CTRL_ADDR, r);
      check(r, 16'h0100);
      for (int i = 0; i < 10; i++) begin
         wr(CTRL_ADDR, {8'h02, DIV_CODE[i], 4'h0});
         period(cyc);
         check(16'(cyc), 16'(4 * DIV_RATIO[i]));
      end
      for (int i = 0; i < 15; i++) begin
         wr(CTRL_ADDR, 16'h0200 | 16'(i));
         period(cyc);
         check(16'(cyc), 16'(2 * SRC_OF[i] + 4));
      end
      give_verdict();
   end
endmodule : tb_top
